//--- src/bpc_pkg.sv
// Package of offsets, field positions and reset values for the bridge power and clock control block
`default_nettype none
package bpc_pkg;
	// ****************************************
	// Register offsets (configuration byte addresses)
	// ****************************************
	localparam logic [7:0] GEN_CTRL_OFFSET = 8'hD4;
	localparam logic [7:0] CLK_DIS_OFFSET = 8'hD8;
	// ****************************************
	// General control field positions
	// ****************************************
	localparam int PREFETCH_OFF_BIT = 19;
	localparam int LS_EXIT_LSB = 16;
	localparam int DS_EXIT_LSB = 13;
	localparam int VC_ON_BIT = 12;
	localparam int STOP_D3_BIT = 11;
	localparam int BEACON_BIT = 10;
	localparam int PWR_SCALE_LSB = 8;
	localparam int PWR_VALUE_LSB = 0;
	localparam int LOW_FIELDS_W = 20;
	// ****************************************
	// Reset values and constant answers
	// ****************************************
	localparam logic [2:0] LS_EXIT_RESET = 3'h6;
	localparam logic [2:0] DS_EXIT_RESET = 3'h6;
	localparam logic [1:0] PWR_SCALE_RESET = 2'h0;
	localparam logic [7:0] PWR_VALUE_RESET = 8'h00;
	localparam logic [7:0] CLK_DIS_RESET = 8'h00;
	localparam logic [6:0] CLK_DIS_MASK = 7'h7F;
	localparam logic [11:0] AER_NEXT_VC = 12'h150;
	localparam logic [11:0] AER_NEXT_NONE = 12'h000;
	// Burst read fetch length: to cache line end, or one doubleword
	localparam logic PREFETCH_LINE = 1'b0;
	localparam logic PREFETCH_DWORD = 1'b1;
	localparam int NUM_CLK_OUT = 7;
endpackage
`default_nettype wire

//--- src/bpc_clk_gate.sv
// Glitch-free gate for one secondary clock output
`timescale 1ns/1ps
`default_nettype none
module bpc_clk_gate (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic disable_req,
	output logic secondary_clock_pin
);
	logic enable_q;
	logic enable_d;
	logic phase_q;
	logic phase_d;

	// ****************************************
	// Divided clock and enable update at low phase
	// ****************************************
	always_comb begin
		phase_d = ~phase_q;
		enable_d = enable_q;
		if (!phase_d) begin
			enable_d = ~disable_req; // R15
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= 1'b0;
			enable_q <= 1'b1;
			secondary_clock_pin <= 1'b0;
		end else begin
			phase_q <= phase_d;
			enable_q <= enable_d;
			secondary_clock_pin <= phase_d & enable_d; // R12
		end
	end
endmodule
`default_nettype wire

//--- src/bpc_top.sv
// Bridge general control low fields and secondary clock output disable register
// Notes on behaviour
// [R1] Prefetch-off clear fetches to cache line end; set fetches one doubleword.
// [R2] Light-sleep exit delay bits 18:16 mirror into capability bits 8:6, reset 110.
// [R3] Light-sleep codes: 000 below 64 ns, doubling, 110 two to four us, 111 above.
// [R4] Deep-sleep exit delay bits 15:13 mirror into capability bits 11:9, reset 110.
// [R5] Virtual channel bit set makes error capability next offset 150h, else 000h.
// [R6] Stop-in-D3 bit set stops secondary clocks in D3; clear keeps them running.
// [R7] Beacon bit clear wakes by WAKE only; set uses beacon and WAKE.
// [R8] Power scale bits 9:8: 00 1.0x, 01 0.1x, 10 0.01x, 11 0.001x.
// [R9] Power value bits 7:0 reset to 00h; requirement is value times scale.
// [R10] Marked bits clear on fundamental reset, global reset or power-on reset.
// [R11] Sticky bits keep values across those resets while on auxiliary power; power-on reset (rst_n) still clears them here.
// [R12] Clock register bits 6..0 each disable the matching secondary clock output.
// [R13] Clock register at D8h, eight bits, resets to 00h.
// [R14] Clock register bit 7 reads zero and ignores writes.
// [R15] Clock outputs start and stop only during a low phase.
`timescale 1ns/1ps
`default_nettype none
module bpc_top #(
	parameter int NUM_CLK = bpc_pkg::NUM_CLK_OUT
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic fundamental_reset_n,
	input wire logic global_reset_in,
	input wire logic aux_powered,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic in_d3,
	output logic [31:0] cfg_rdata,
	output logic prefetch_off,
	output logic [2:0] cap_light_sleep_exit_delay,
	output logic [2:0] cap_deep_sleep_exit_delay,
	output logic [11:0] aer_next_offset,
	output logic beacon_wake_on,
	output logic [1:0] min_power_scale,
	output logic [7:0] min_power_value,
	output logic [NUM_CLK-1:0] secondary_clock_pin
);
	// ****************************************
	// Parameter check
	// ****************************************
	if (NUM_CLK < 1 || NUM_CLK > bpc_pkg::NUM_CLK_OUT) begin : g_bad_num_clk
		$error("NUM_CLK must be 1 to 7");
	end

	// ****************************************
	// Register images and reset value
	// ****************************************
	// Low twenty bits of general control, as stored
	typedef logic [bpc_pkg::LOW_FIELDS_W-1:0] bpc_gen_type;

	// Reset image built from the field constants, so a moved field cannot skew the rest
	localparam bpc_gen_type GEN_RESET = (bpc_gen_type'(bpc_pkg::LS_EXIT_RESET) << bpc_pkg::LS_EXIT_LSB)
		| (bpc_gen_type'(bpc_pkg::DS_EXIT_RESET) << bpc_pkg::DS_EXIT_LSB)
		| (bpc_gen_type'(bpc_pkg::PWR_SCALE_RESET) << bpc_pkg::PWR_SCALE_LSB)
		| (bpc_gen_type'(bpc_pkg::PWR_VALUE_RESET) << bpc_pkg::PWR_VALUE_LSB);

	bpc_gen_type gen_q;
	bpc_gen_type gen_d;
	logic [7:0] clk_dis_q;
	logic [7:0] clk_dis_d;
	logic [31:0] rdata_d;
	logic soft_clear;
	logic stop_all;
	logic [31:0] gen_wmask;

	// Decoded access strobes
	logic wr_gen;
	logic wr_clk;
	logic rd_gen;
	logic rd_clk;

	// Next values of the registered field outputs
	logic prefetch_off_d;
	logic [2:0] cap_ls_delay_d;
	logic [2:0] cap_ds_delay_d;
	logic [11:0] aer_next_d;
	logic beacon_wake_d;
	logic [1:0] min_power_scale_d;
	logic [7:0] min_power_value_d;

	// Per-output stop requests
	logic [NUM_CLK-1:0] clk_off_req;

	// ****************************************
	// Reset events other than power-on
	// ****************************************
	always_comb begin
		soft_clear = ~fundamental_reset_n | global_reset_in; // R10
	end

	// ****************************************
	// Address decode
	// ****************************************
	always_comb begin
		wr_gen = 1'b0;
		wr_clk = 1'b0;
		rd_gen = 1'b0;
		rd_clk = 1'b0;
		if (cfg_addr == bpc_pkg::GEN_CTRL_OFFSET) begin
			wr_gen = cfg_wr;
			rd_gen = cfg_rd;
		end else if (cfg_addr == bpc_pkg::CLK_DIS_OFFSET) begin
			wr_clk = cfg_wr & cfg_be[0]; // R13
			rd_clk = cfg_rd; // R13
		end
	end

	// ****************************************
	// Register write and soft reset
	// ****************************************
	always_comb begin
		gen_wmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
		gen_d = gen_q;
		clk_dis_d = clk_dis_q;
		if (wr_gen) begin
			gen_d = (gen_q & ~gen_wmask[bpc_pkg::LOW_FIELDS_W-1:0])
				| (cfg_wdata[bpc_pkg::LOW_FIELDS_W-1:0] & gen_wmask[bpc_pkg::LOW_FIELDS_W-1:0]);
		end else if (wr_clk) begin
			clk_dis_d = {1'b0, cfg_wdata[bpc_pkg::NUM_CLK_OUT-1:0] & bpc_pkg::CLK_DIS_MASK}; // R13 R14
		end
		if (soft_clear) begin
			gen_d[bpc_pkg::PREFETCH_OFF_BIT] = 1'b0; // R10
			gen_d[bpc_pkg::LS_EXIT_LSB +: 3] = bpc_pkg::LS_EXIT_RESET;
			gen_d[bpc_pkg::DS_EXIT_LSB +: 3] = bpc_pkg::DS_EXIT_RESET;
			gen_d[bpc_pkg::VC_ON_BIT] = 1'b0;
			gen_d[bpc_pkg::PWR_SCALE_LSB +: 2] = bpc_pkg::PWR_SCALE_RESET;
			gen_d[bpc_pkg::PWR_VALUE_LSB +: 8] = bpc_pkg::PWR_VALUE_RESET;
			clk_dis_d = bpc_pkg::CLK_DIS_RESET;
			if (!aux_powered) begin
				gen_d[bpc_pkg::STOP_D3_BIT] = 1'b0; // R11
				gen_d[bpc_pkg::BEACON_BIT] = 1'b0; // R11
			end
		end
	end

	// ****************************************
	// Read data mux
	// ****************************************
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (rd_gen) begin
			rdata_d[bpc_pkg::LOW_FIELDS_W-1:0] = gen_q;
		end else if (rd_clk) begin
			rdata_d[bpc_pkg::NUM_CLK_OUT-1:0] = clk_dis_q[bpc_pkg::NUM_CLK_OUT-1:0]; // R14
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gen_q <= GEN_RESET; // R2 R4 R9
			clk_dis_q <= bpc_pkg::CLK_DIS_RESET; // R13
			cfg_rdata <= 32'h0000_0000;
		end else begin
			gen_q <= gen_d;
			clk_dis_q <= clk_dis_d;
			cfg_rdata <= rdata_d;
		end
	end

	// ****************************************
	// Field output next values
	// ****************************************
	always_comb begin
		prefetch_off_d = gen_q[bpc_pkg::PREFETCH_OFF_BIT] ? bpc_pkg::PREFETCH_DWORD : bpc_pkg::PREFETCH_LINE; // R1
		cap_ls_delay_d = gen_q[bpc_pkg::LS_EXIT_LSB +: 3]; // R2 R3
		cap_ds_delay_d = gen_q[bpc_pkg::DS_EXIT_LSB +: 3]; // R4
		aer_next_d = gen_q[bpc_pkg::VC_ON_BIT] ? bpc_pkg::AER_NEXT_VC : bpc_pkg::AER_NEXT_NONE; // R5
		beacon_wake_d = gen_q[bpc_pkg::BEACON_BIT]; // R7
		min_power_scale_d = gen_q[bpc_pkg::PWR_SCALE_LSB +: 2]; // R8
		min_power_value_d = gen_q[bpc_pkg::PWR_VALUE_LSB +: 8]; // R9
	end

	// ****************************************
	// Decoded outputs, all registered
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prefetch_off <= bpc_pkg::PREFETCH_LINE;
			cap_light_sleep_exit_delay <= bpc_pkg::LS_EXIT_RESET;
			cap_deep_sleep_exit_delay <= bpc_pkg::DS_EXIT_RESET;
			aer_next_offset <= bpc_pkg::AER_NEXT_NONE;
			beacon_wake_on <= 1'b0;
			min_power_scale <= bpc_pkg::PWR_SCALE_RESET;
			min_power_value <= bpc_pkg::PWR_VALUE_RESET;
		end else begin
			prefetch_off <= prefetch_off_d;
			cap_light_sleep_exit_delay <= cap_ls_delay_d;
			cap_deep_sleep_exit_delay <= cap_ds_delay_d;
			aer_next_offset <= aer_next_d;
			beacon_wake_on <= beacon_wake_d;
			min_power_scale <= min_power_scale_d;
			min_power_value <= min_power_value_d;
		end
	end

	// ****************************************
	// Secondary clock outputs
	// ****************************************
	always_comb begin
		stop_all = gen_q[bpc_pkg::STOP_D3_BIT] & in_d3; // R6
		clk_off_req = clk_dis_q[NUM_CLK-1:0] | {NUM_CLK{stop_all}}; // R6 R12
	end

	// One gate per output; each holds its enable until a low phase
	for (genvar i = 0; i < NUM_CLK; i++) begin : g_clk
		bpc_clk_gate u_gate (
			.mclk(mclk),
			.rst_n(rst_n),
			.disable_req(clk_off_req[i]), // R12
			.secondary_clock_pin(secondary_clock_pin[i])
		);
	end
endmodule
`default_nettype wire

//--- sim/bpc_top_asserts.sv
// Assertion checker for the bridge power and clock control block
`timescale 1ns/1ps
`default_nettype none
module bpc_top_asserts #(parameter int NUM_CLK = 7) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic fundamental_reset_n,
	input wire logic global_reset_in,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic prefetch_off,
	input wire logic [2:0] cap_light_sleep_exit_delay,
	input wire logic [11:0] aer_next_offset,
	input wire logic [NUM_CLK-1:0] secondary_clock_pin
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire logic quiet = fundamental_reset_n && !global_reset_in;
	// Low-lane write to general control, no soft reset behind it
	sequence s_wr_gen;
		cfg_wr && cfg_addr == 8'hD4 && cfg_be[2:0] == 3'h7 && quiet ##1 quiet;
	endsequence
	// Clock 0 disabled, then left alone for four cycles
	sequence s_off0;
		cfg_wr && cfg_addr == 8'hD8 && cfg_be[0] && cfg_wdata[0] && quiet ##1 (quiet && !cfg_wr) [*4];
	endsequence
	// Field outputs follow the written value two cycles later
	AST_PREFETCH: assert property (s_wr_gen |-> ##1 prefetch_off == $past(cfg_wdata[19], 2)) else $error("prefetch");
	AST_LS_MIRROR: assert property (s_wr_gen |-> ##1 cap_light_sleep_exit_delay == $past(cfg_wdata[18:16], 2))
		else $error("light sleep");
	AST_AER_NEXT: assert property (s_wr_gen |-> ##1 aer_next_offset == ($past(cfg_wdata[12], 2) ? 12'h150 : 12'h000))
		else $error("aer");
	AST_RD_RSVD: assert property (cfg_rd && cfg_addr == 8'hD8 |=> cfg_rdata[31:7] == 25'h0) else $error("bit7");
	AST_RD_IDLE: assert property (!(cfg_rd && (cfg_addr == 8'hD4 || cfg_addr == 8'hD8)) |=> cfg_rdata == 32'h0)
		else $error("rdata");
	AST_SOFT_CLR: assert property (!quiet |-> ##2 !prefetch_off && cap_light_sleep_exit_delay == 3'h6) else $error("soft");
	AST_CLK_OFF: assert property (s_off0 |=> !secondary_clock_pin[0] [*3]) else $error("clk off");
	AST_CLK_PULSE: assert property ($rose(secondary_clock_pin[0]) |=> $fell(secondary_clock_pin[0])) else $error("runt");
endmodule
bind bpc_top bpc_top_asserts #(.NUM_CLK(NUM_CLK)) u_chk (
	.mclk(mclk),
	.rst_n(rst_n),
	.fundamental_reset_n(fundamental_reset_n),
	.global_reset_in(global_reset_in),
	.cfg_wr(cfg_wr),
	.cfg_rd(cfg_rd),
	.cfg_addr(cfg_addr),
	.cfg_be(cfg_be),
	.cfg_wdata(cfg_wdata),
	.cfg_rdata(cfg_rdata),
	.prefetch_off(prefetch_off),
	.cap_light_sleep_exit_delay(cap_light_sleep_exit_delay),
	.aer_next_offset(aer_next_offset),
	.secondary_clock_pin(secondary_clock_pin)
);
`default_nettype wire

//--- sim/test_bridge_power_and_clock_output_control.sv
// Self-checking bench for the bridge power and clock control block
`timescale 1ns/1ps
`default_nettype none
module test_bridge_power_and_clock_output_control;
	logic mclk = 1'b0, rst_n = 1'b0, fundamental_reset_n = 1'b1, global_reset_in = 1'b0;
	logic aux_powered = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
	logic in_d3 = 1'b0, prefetch_off, beacon_wake_on;
	logic [7:0] cfg_addr = 8'h00, min_power_value;
	logic [3:0] cfg_be = 4'hF;
	logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
	logic [2:0] cap_light_sleep_exit_delay, cap_deep_sleep_exit_delay;
	logic [11:0] aer_next_offset;
	logic [1:0] min_power_scale;
	logic [6:0] secondary_clock_pin;
	int fails = 0, n_checks = 0;
	bpc_top DUT (
		.mclk(mclk),
		.rst_n(rst_n),
		.fundamental_reset_n(fundamental_reset_n),
		.global_reset_in(global_reset_in),
		.aux_powered(aux_powered),
		.cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr),
		.cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata),
		.in_d3(in_d3),
		.cfg_rdata(cfg_rdata),
		.prefetch_off(prefetch_off),
		.cap_light_sleep_exit_delay(cap_light_sleep_exit_delay),
		.cap_deep_sleep_exit_delay(cap_deep_sleep_exit_delay),
		.aer_next_offset(aer_next_offset),
		.beacon_wake_on(beacon_wake_on),
		.min_power_scale(min_power_scale),
		.min_power_value(min_power_value),
		.secondary_clock_pin(secondary_clock_pin)
	);
	initial forever #2.5 mclk = ~mclk;
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One config write, or one read compared against d
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(negedge mclk);
		{cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {w, !w, a, d};
		@(negedge mclk);
		{cfg_wr, cfg_rd} = 2'b00;
		if (!w) chk(cfg_rdata, d);
		else repeat (2) @(negedge mclk);
	endtask
	// Which clock outputs went high after settling
	task automatic clk_seen(input logic [6:0] exp);
		logic [6:0] acc;
		acc = 7'h00;
		repeat (5) @(negedge mclk);
		repeat (4) begin
			@(negedge mclk);
			acc = acc | secondary_clock_pin;
		end
		chk({25'h0, acc}, {25'h0, exp});
	endtask
	// Counts and verdict
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(negedge mclk);
		rst_n = 1;
		xfer(1'b0, 8'hD4, 32'h0006C000);
		xfer(1'b0, 8'hD8, 32'h0);
		clk_seen(7'h7F);
		xfer(1'b1, 8'hD4, 32'hFFFFFFFF);
		chk({prefetch_off, aer_next_offset, beacon_wake_on, min_power_scale, min_power_value},
			{1'b1, 12'h150, 1'b1, 2'h3, 8'hFF});
		xfer(1'b0, 8'hD4, 32'h000FFFFF);
		for (int i = 0; i < 8; i++) begin
			xfer(1'b1, 8'hD4, (i << 16) | (i << 13) | ((i & 3) << 8) | i);
			chk({prefetch_off, aer_next_offset, beacon_wake_on, cap_light_sleep_exit_delay,
				cap_deep_sleep_exit_delay, min_power_scale, min_power_value}, {14'h0, i[2:0], i[2:0], i[1:0], i[7:0]});
		end
		xfer(1'b1, 8'hD8, 32'hFF);
		xfer(1'b0, 8'hD8, 32'h7F);
		clk_seen(7'h00);
		xfer(1'b1, 8'hD8, 32'h55);
		clk_seen(7'h2A);
		xfer(1'b1, 8'hD8, 32'h0);
		xfer(1'b1, 8'hD4, 32'h800);
		in_d3 = 1;
		clk_seen(7'h00);
		xfer(1'b1, 8'hD4, 32'h400);
		clk_seen(7'h7F);
		xfer(1'b1, 8'hD8, 32'h3);
		global_reset_in = 1;
		@(negedge mclk);
		global_reset_in = 0;
		xfer(1'b0, 8'hD4, 32'h0006C000);
		xfer(1'b0, 8'hD8, 32'h0);
		aux_powered = 1;
		xfer(1'b1, 8'hD4, 32'hC55);
		fundamental_reset_n = 0;
		@(negedge mclk);
		fundamental_reset_n = 1;
		xfer(1'b0, 8'hD4, 32'h0006CC00);
		tally_and_finish;
	end
endmodule
`default_nettype wire
